// [design/wiper_host_pkg.sv]
package wiper_host_pkg;
    // ----------------------------------------------------------------
    // Position range
    // ----------------------------------------------------------------
    localparam int POS_W = 7;                       // Counter width in the device
    localparam logic [6:0] POS_MAX = 7'h7F;         // Top tap
    localparam logic [6:0] POS_MIN = 7'h00;         // Bottom tap
    localparam logic [6:0] POS_RESET = 7'h40;       // Midscale after power-up

    // ----------------------------------------------------------------
    // Timing, in ns, with cycle counts at 20 MHz
    // ----------------------------------------------------------------
    localparam int CLK_NS = 50;                     // Clock period
    localparam int T_SEL_SETUP_NS = 100;            // Select low to strobe fall
    localparam int T_DIR_HOLD_NS = 100;             // Strobe high to direction change
    localparam int T_DIR_SETUP_NS = 1000;           // Direction to strobe fall
    localparam int T_STB_LOW_NS = 1000;             // Strobe low period
    localparam int T_STB_HIGH_NS = 1000;            // Strobe high period
    localparam int T_LOCK_SETUP_NS = 1000;          // Strobe high to select high when locking
    localparam int SEL_SETUP_CYC = (T_SEL_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIR_HOLD_CYC = (T_DIR_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIR_SETUP_CYC = (T_DIR_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STB_LOW_CYC = (T_STB_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STB_HIGH_CYC = (T_STB_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOCK_SETUP_CYC = (T_LOCK_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 8;                       // Width of the delay timer
endpackage

// [design/wiper_delay_timer.sv]
`timescale 1ns/1ps
// Loadable down-counter: done_o is high while the count is zero
module wiper_delay_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic load_i,
    input wire logic [7:0] value_i,
    // Status
    output logic done_o
);
    logic [7:0] count_reg; // Cycles still to wait

    // Load wins over counting so a new wait starts cleanly
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= 8'h00;
        end else if (load_i) begin
            count_reg <= value_i;
        end else if (count_reg != 8'h00) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    assign done_o = (count_reg == 8'h00);
endmodule // wiper_delay_timer

// [design/wiper_host_ctrl.sv]
// Functional notes
// - Normal end: raise select, then strobe
// - Direction is fixed for the whole session
// - Hold select and strobe high from reset
// - Select rise with strobe low steps once
`timescale 1ns/1ps
module wiper_host_ctrl (
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    // Command from the user side
    input wire logic CMD_VALID_I,
    input wire logic CMD_UP_I,
    input wire logic [6:0] CMD_STEPS_I,
    input wire logic CMD_LOCK_I,
    output logic CMD_READY_O,
    // Pins toward the potentiometer
    output logic SEL_N_O,
    output logic STEP_N_O,
    output logic DIR_O,
    // Tracked device state
    output logic [6:0] POSITION_O,
    output logic LOCKED_O,
    output logic DONE_O
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg; // First stage, read only by the second
    logic rst_n_reg;    // Reset copy used by all logic

    // Two flops so the release is clean against CLOCK_I
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // An unlocked session must end with select rising while the strobe is
    // low, and that rise itself moves the wiper once. So an unlocked session
    // of N steps lowers the strobe before selecting (ignored while
    // deselected), makes N-1 counted falls, and lets the select rise make
    // the last step. A zero-step unlocked session cannot avoid a move, so
    // it leaves select and strobe alone and only loads the direction pin.
    typedef enum logic [7:0] {
        ST_IDLE    = 8'h01, // Select high, strobe high
        ST_SETDIR  = 8'h02, // Direction driven, setup wait
        ST_SELECT  = 8'h04, // Select low, setup wait
        ST_PH1     = 8'h08, // First half of a strobe pulse
        ST_PH2     = 8'h10, // Second half of a strobe pulse
        ST_RELSEL  = 8'h20, // Select raised
        ST_RELSTB  = 8'h40, // Strobe raised, hold after release
        ST_DEAD    = 8'h80  // Device locked, pins parked
    } state_t;

    state_t state_reg;          // Current phase
    logic [6:0] left_reg;       // Pulses still to issue
    logic lock_req_reg;         // Session ends in a lock
    logic load;                 // Restart the delay timer
    logic [7:0] load_val;       // Cycles for the next wait
    logic tmr_done;             // Delay elapsed
    logic go;                   // Command taken this cycle
    logic skip;                 // Zero-step unlocked command, select and strobe untouched
    logic wait_end;             // Select setup or a pulse finished
    logic toggle;               // Strobe flips at this edge
    logic release_sel;          // Select rises at this edge
    logic step_evt;             // Device counter moves at this edge

    wiper_delay_timer u_timer (
        .clk_i(CLOCK_I),
        .rst_n_i(rst_n_reg),
        .load_i(load),
        .value_i(load_val),
        .done_o(tmr_done)
    );

    // Shared decode of the phase ends
    always_comb begin
        go = (state_reg == ST_IDLE) && CMD_VALID_I && !LOCKED_O;
        skip = go && (CMD_STEPS_I == 7'h00) && !CMD_LOCK_I;
        wait_end = (state_reg == ST_SELECT || state_reg == ST_PH2) && tmr_done;
        toggle = (wait_end && left_reg != 7'h00) || (state_reg == ST_PH1 && tmr_done);
        release_sel = wait_end && left_reg == 7'h00;
        // Strobe fall while selected, or select rise with strobe low
        step_evt = !SEL_N_O && ((toggle && STEP_N_O) || (release_sel && !STEP_N_O));
    end

    // Timer loads on each phase change that needs a spacing
    always_comb begin
        load = 1'b0;
        load_val = 8'h00;
        case (state_reg)
            ST_IDLE: begin
                if (go && !skip) begin
                    load = 1'b1;
                    load_val = 8'(wiper_host_pkg::DIR_SETUP_CYC);
                end
            end
            ST_SETDIR: begin
                if (tmr_done) begin
                    load = 1'b1;
                    load_val = 8'(wiper_host_pkg::SEL_SETUP_CYC);
                end
            end
            ST_SELECT, ST_PH2: begin
                if (toggle) begin
                    load = 1'b1;
                    load_val = lock_req_reg ? 8'(wiper_host_pkg::STB_LOW_CYC)
                                            : 8'(wiper_host_pkg::STB_HIGH_CYC);
                end else if (release_sel) begin
                    load = 1'b1;
                    load_val = 8'(wiper_host_pkg::SEL_SETUP_CYC);
                end
            end
            ST_PH1: begin
                if (tmr_done && lock_req_reg && left_reg == 7'h01) begin
                    // Last high before a lock also covers the lock setup
                    load = 1'b1;
                    load_val = 8'(wiper_host_pkg::LOCK_SETUP_CYC);
                end else if (tmr_done) begin
                    load = 1'b1;
                    load_val = lock_req_reg ? 8'(wiper_host_pkg::STB_HIGH_CYC)
                                            : 8'(wiper_host_pkg::STB_LOW_CYC);
                end
            end
            ST_RELSEL: begin
                if (tmr_done) begin
                    load = 1'b1;
                    load_val = 8'(wiper_host_pkg::DIR_HOLD_CYC);
                end
            end
            default: begin
                load = 1'b0;
            end
        endcase
    end

    // Phase sequencing
    always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (go) begin
                        state_reg <= skip ? ST_RELSTB : ST_SETDIR;
                    end
                end
                ST_SETDIR: begin
                    if (tmr_done) begin
                        state_reg <= ST_SELECT;
                    end
                end
                ST_SELECT, ST_PH2: begin
                    if (toggle) begin
                        state_reg <= ST_PH1;
                    end else if (release_sel) begin
                        state_reg <= ST_RELSEL;
                    end
                end
                ST_PH1: begin
                    if (tmr_done) begin
                        state_reg <= ST_PH2;
                    end
                end
                ST_RELSEL: begin
                    if (tmr_done) begin
                        state_reg <= lock_req_reg ? ST_DEAD : ST_RELSTB;
                    end
                end
                ST_RELSTB: begin
                    if (tmr_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_DEAD: begin
                    state_reg <= ST_DEAD;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Command capture and pulse budget; unlocked sessions owe one pulse less
    always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            left_reg <= 7'h00;
            lock_req_reg <= 1'b0;
            DIR_O <= 1'b0;
        end else if (go) begin
            left_reg <= CMD_LOCK_I ? CMD_STEPS_I : CMD_STEPS_I - 7'h01;
            lock_req_reg <= CMD_LOCK_I;
            DIR_O <= CMD_UP_I;
        end else if (state_reg == ST_PH1 && tmr_done) begin
            left_reg <= left_reg - 7'h01;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Strobe parks low before select in unlocked sessions, high in locking ones
    always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            SEL_N_O <= 1'b1;
            STEP_N_O <= 1'b1;
        end else begin
            if (go && !skip) begin
                STEP_N_O <= CMD_LOCK_I;
            end else if (toggle) begin
                STEP_N_O <= !STEP_N_O;
            end else if (state_reg == ST_RELSEL && tmr_done && !lock_req_reg) begin
                STEP_N_O <= 1'b1;
            end
            if (state_reg == ST_SETDIR && tmr_done) begin
                SEL_N_O <= 1'b0;
            end else if (release_sel) begin
                SEL_N_O <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Device state model
    // ----------------------------------------------------------------
    // Mirrors the device counter: midscale at reset, saturating steps
    always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            POSITION_O <= wiper_host_pkg::POS_RESET;
            LOCKED_O <= 1'b0;
        end else begin
            if (!LOCKED_O && step_evt) begin
                if (DIR_O && POSITION_O != wiper_host_pkg::POS_MAX) begin
                    POSITION_O <= POSITION_O + 7'h01;
                end else if (!DIR_O && POSITION_O != wiper_host_pkg::POS_MIN) begin
                    POSITION_O <= POSITION_O - 7'h01;
                end
            end
            if (release_sel && !SEL_N_O && STEP_N_O) begin
                LOCKED_O <= 1'b1;
            end
        end
    end

    // Ready and done flags; the device's one-hot tap and make-before-break
    // are internal to it, so the host waits no settle time
    always_ff @(posedge CLOCK_I or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            CMD_READY_O <= 1'b0;
            DONE_O <= 1'b0;
        end else begin
            CMD_READY_O <= (state_reg == ST_IDLE) && !CMD_VALID_I && !LOCKED_O;
            DONE_O <= (state_reg == ST_RELSTB && tmr_done)
                      || (state_reg == ST_RELSEL && tmr_done && lock_req_reg);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_idle_pins: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        state_reg == ST_IDLE |-> SEL_N_O && STEP_N_O)
        else $error("pins not parked in idle");
    a_strobe_sel: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        !STEP_N_O && SEL_N_O |-> !lock_req_reg)
        else $error("strobe low while deselected in a locking session");
    a_release_order: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        $rose(SEL_N_O) |-> STEP_N_O == lock_req_reg)
        else $error("select raised with the wrong strobe level");
    a_sat_top: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        $past(POSITION_O) == wiper_host_pkg::POS_MAX |-> POSITION_O != wiper_host_pkg::POS_MIN)
        else $error("position wrapped at top");
    a_sat_bottom: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        $past(POSITION_O) == wiper_host_pkg::POS_MIN |-> POSITION_O != wiper_host_pkg::POS_MAX)
        else $error("position wrapped at bottom");
    a_one_step: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        $changed(POSITION_O) |-> !STEP_N_O && (POSITION_O == $past(POSITION_O) + 7'h01
                                              || POSITION_O == $past(POSITION_O) - 7'h01))
        else $error("position moved other than one step on a strobe");
    a_lock_hold: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        LOCKED_O |=> LOCKED_O && $stable(POSITION_O) && SEL_N_O)
        else $error("locked state disturbed");
    a_dir_stable: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        !STEP_N_O && !SEL_N_O |-> $stable(DIR_O))
        else $error("direction moved during strobe low");
    a_low_width: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        $fell(STEP_N_O) |-> !STEP_N_O [*8])
        else $error("strobe low too short");
    c_step_up: cover property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        $changed(POSITION_O) && DIR_O);
    c_step_down: cover property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
        $changed(POSITION_O) && !DIR_O);
    c_locked: cover property (@(posedge CLOCK_I) disable iff (!rst_n_reg) $rose(LOCKED_O));
    c_done: cover property (@(posedge CLOCK_I) disable iff (!rst_n_reg) DONE_O);
endmodule // wiper_host_ctrl

// [sim/wiper_pot_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Behavioural potentiometer control section, edge driven, no clock
// ----------------------------------------------------------------
module wiper_pot_model #(
    parameter int SETTLE_NS = 1000  // Tap settle interval, plain default
) (
    // Supply good, stands in for the power-on threshold
    input wire logic pwr_ok_i,
    // Pins from the host
    input wire logic sel_n_i,
    input wire logic step_n_i,
    input wire logic dir_i,
    // Observed device state
    output logic [6:0] pos_o,
    output logic locked_o,
    output logic [127:0] tap_o
);
    // Power-up: midscale, lock clear, single tap closed
    always @(posedge pwr_ok_i) begin
        pos_o = 7'h40;
        locked_o = 1'b0;
        tap_o = 128'h1 << 7'h40;
    end

    // One saturating step; the new tap closes before the old opens
    task automatic step_once();
        logic [6:0] nxt;
        nxt = pos_o;
        if (dir_i && pos_o != 7'h7F) begin
            nxt = pos_o + 7'h01;
        end else if (!dir_i && pos_o != 7'h00) begin
            nxt = pos_o - 7'h01;
        end
        pos_o = nxt;
        tap_o = tap_o | (128'h1 << nxt);
        // Old taps open only after the settle time, so taps overlap briefly
        fork
            #(SETTLE_NS) tap_o = 128'h1 << pos_o;
        join_none
    endtask

    // Falling strobe counts only while selected and unlocked
    always @(negedge step_n_i) begin
        if (pwr_ok_i && !sel_n_i && !locked_o) begin
            step_once();
        end
    end

    // Select rising: lock with strobe high, single step with strobe low
    always @(posedge sel_n_i) begin
        if (pwr_ok_i && step_n_i) begin
            locked_o = 1'b1;
        end else if (pwr_ok_i && !locked_o) begin
            step_once();
        end
    end
endmodule // wiper_pot_model

// [sim/updown_wiper_counter_test.sv]
`timescale 1ns/1ps
// Compare and count; four-state inequality so unknowns never match
`define CHECK(what, exp, act) \
    begin \
        num_checks++; \
        if ((act) !== (exp)) begin \
            error_cnt++; \
            $display("mismatch %s expected %h seen %h", what, exp, act); \
        end \
    end
module updown_wiper_counter_test;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk = 1'b0; // 20 MHz system clock
    logic rst_n = 1'b0; // Also the supply-good of the model
    logic cmd_valid = 1'b0;
    logic cmd_up = 1'b0;
    logic [6:0] cmd_steps = 7'h00;
    logic cmd_lock = 1'b0;
    logic ready, sel_n, step_n, dir, locked, done;
    logic [6:0] position, dev_pos;
    logic dev_locked;
    logic [127:0] dev_tap;
    int error_cnt = 0;
    int num_checks = 0;
    int fall_cnt = 0; // Strobe falls seen on the pin

    always #25 clk = ~clk;
    always @(negedge step_n) fall_cnt++;

    // ----------------------------------------------------------------
    // Instances
    // ----------------------------------------------------------------
    wiper_host_ctrl wiper_host_ctrl_i (.CLOCK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(cmd_valid),
        .CMD_UP_I(cmd_up), .CMD_STEPS_I(cmd_steps), .CMD_LOCK_I(cmd_lock), .CMD_READY_O(ready),
        .SEL_N_O(sel_n), .STEP_N_O(step_n), .DIR_O(dir), .POSITION_O(position),
        .LOCKED_O(locked), .DONE_O(done));
    wiper_pot_model wiper_pot_model_i (.pwr_ok_i(rst_n), .sel_n_i(sel_n), .step_n_i(step_n),
        .dir_i(dir), .pos_o(dev_pos), .locked_o(dev_locked), .tap_o(dev_tap));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Verdict and end of run, the only exit
    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One session: wait for ready, offer for one edge, wait for done
    task automatic run_cmd(input logic up, input logic [6:0] steps, input logic lock);
        int n;
        int falls0;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        falls0 = fall_cnt;
        cmd_valid = 1'b1;
        cmd_up = up;
        cmd_steps = steps;
        cmd_lock = lock;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        // Bounded wait: about 45 cycles a step at most
        while (done !== 1'b1 && n < 8000) begin
            @(negedge clk);
            n++;
        end
        `CHECK("done", 1'b1, done)
        `CHECK("strobe falls", int'(steps), fall_cnt - falls0)
        repeat (30) @(negedge clk);
    endtask

    // Host copy, device copy and the single closed tap
    task automatic check_state(input logic [6:0] exp_pos, input logic exp_lock);
        `CHECK("position", exp_pos, position)
        `CHECK("device position", exp_pos, dev_pos)
        `CHECK("device tap", 128'h1 << exp_pos, dev_tap)
        `CHECK("locked", exp_lock, locked)
        `CHECK("device locked", exp_lock, dev_locked)
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Idle pins after power-up, midscale position
    task automatic test_reset();
        `CHECK("select idle", 1'b1, sel_n)
        `CHECK("strobe idle", 1'b1, step_n)
        `CHECK("ready", 1'b1, ready)
        check_state(7'h40, 1'b0);
    endtask

    // Up then down in separate sessions, direction honoured each time
    task automatic test_up_down();
        run_cmd(1'b1, 7'h03, 1'b0);
        check_state(7'h43, 1'b0);
        run_cmd(1'b0, 7'h05, 1'b0);
        check_state(7'h3E, 1'b0);
    endtask

    // Saturation at both ends, extra steps change nothing
    task automatic test_ends();
        run_cmd(1'b1, 7'h64, 1'b0);
        check_state(7'h7F, 1'b0);
        run_cmd(1'b1, 7'h01, 1'b0);
        check_state(7'h7F, 1'b0);
        run_cmd(1'b0, 7'h7F, 1'b0);
        check_state(7'h00, 1'b0);
        run_cmd(1'b0, 7'h02, 1'b0);
        check_state(7'h00, 1'b0);
    endtask

    // Zero-step unlocked session leaves select and strobe idle and the count alone
    task automatic test_zero();
        run_cmd(1'b1, 7'h00, 1'b0);
        check_state(7'h00, 1'b0);
    endtask

    // Lock session, then a refused command leaves pins idle
    task automatic test_lock();
        int i;
        run_cmd(1'b1, 7'h04, 1'b1);
        check_state(7'h04, 1'b1);
        cmd_valid = 1'b1;
        cmd_steps = 7'h02;
        cmd_lock = 1'b0;
        for (i = 0; i < 60; i++) begin
            @(negedge clk);
            `CHECK("select held", 1'b1, sel_n)
            `CHECK("ready locked", 1'b0, ready)
        end
        cmd_valid = 1'b0;
        check_state(7'h04, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        test_reset();
        test_up_down();
        test_ends();
        test_zero();
        test_lock();
        finish_test();
    end

    // About 10500 cycles expected; give ample margin
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule // updown_wiper_counter_test
